/* File: verilog/arf_consts.svh */
// constants of the result bus formatter
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH
`define ARF_RES_W 18
`define ARF_MODE_FULL 2'h0
`define ARF_MODE_WORD 2'h1
`define ARF_MODE_BYTE 2'h2
`define ARF_MODE_SERIAL 2'h3
`define ARF_RESULT_RST 18'h00000
`define ARF_CODING_RST 1'h1
`define ARF_CFG_W 4
`define ARF_CFG_RST 4'h0
`define ARF_DOUT_RST 18'h00000
`define ARF_OE_RST 18'h00000
`define ARF_EN_RST 1'h0
`endif

/* File: verilog/arf_pkg.sv */
// types of the result bus formatter
package arf_pkg;
  typedef enum logic [1:0] {ARF_FULL, ARF_WORD, ARF_BYTE, ARF_SERIAL} arf_mode_t;
endpackage

/* File: verilog/arf_bus_if.sv */
// result and formatted bus between formatter top and lane mapper
`timescale 1ns/100ps
interface arf_bus_if;
  logic [17:0] result;
  logic [1:0] mode;
  logic codingSel;
  logic segLo;
  logic segHi;
  logic [17:0] dataOut;
  logic [17:0] dataOe;
  modport top (output result, mode, codingSel, segLo, segHi, input dataOut, dataOe);
  modport mapper (input result, mode, codingSel, segLo, segHi, output dataOut, dataOe);
endinterface

/* File: verilog/arf_lane_map.sv */
// combinational lane mapping of the result onto the data lines
`timescale 1ns/100ps
`include "arf_consts.svh"
module arf_lane_map
  import arf_pkg::*;
(
  arf_bus_if.mapper bus
);
  logic [17:0] coded;
  always_comb
  begin
    // coding select: high straight binary, low two's complement
    coded = bus.codingSel ? bus.result : {~bus.result[17], bus.result[16:0]};
    bus.dataOut = 18'h00000;
    bus.dataOe = 18'h00000;
    unique case (bus.mode)
      `ARF_MODE_FULL:
      begin
        bus.dataOut = coded;
        bus.dataOe = 18'h3ffff;
      end
      `ARF_MODE_WORD:
      begin
        bus.dataOe = 18'h3fffc;
        if (bus.segLo)
          bus.dataOut = {14'h0000, coded[1:0], 2'h0};
        else
          bus.dataOut = {coded[17:2], 2'h0};
      end
      `ARF_MODE_BYTE:
      begin
        bus.dataOe = 18'h3fc00;
        if (!bus.segLo && !bus.segHi)
          bus.dataOut = {coded[17:10], 10'h000};
        else if (!bus.segLo)
          bus.dataOut = {coded[9:2], 10'h000};
        else if (!bus.segHi)
          bus.dataOut = {6'h00, coded[1:0], 10'h000};
        else
          bus.dataOut = {coded[1:0], 16'h0000};
      end
      `ARF_MODE_SERIAL:
      begin
        bus.dataOut = 18'h00000;
        bus.dataOe = 18'h00000;
      end
    endcase
  end
endmodule

/* File: verilog/arf_formatter.sv */
// result bus formatter: latches result, maps lanes, gates drivers
`timescale 1ns/100ps
`include "arf_consts.svh"
module arf_formatter
  import arf_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  // conversion result
  input wire logic [17:0] resultIn,
  input wire logic resultValid,
  // format and segment pins
  input wire logic bus_format_sel_lsb,
  input wire logic bus_format_sel_msb,
  input wire logic coding_format_sel,
  input wire logic segment_addr_lo,
  input wire logic segment_addr_hi,
  // configuration source
  input wire logic config_source_sel,
  input wire logic [3:0] cfgPins,
  input wire logic [3:0] serialCfg,
  input wire logic serialCfgLoad,
  // read strobes
  input wire logic chipSelect_n,
  input wire logic readData_n,
  // reference control
  input wire logic ref_power_down,
  input wire logic ref_buffer_power_down,
  // parallel bus
  output logic [17:0] dataOut,
  output logic [17:0] dataOe,
  // serial, configuration and reference status
  output logic serialOutEn,
  output logic [3:0] cfgEffective,
  output logic refEnable,
  output logic bufEnable,
  output logic convAbort
);
  arf_bus_if bus();

  // decoded pins
  arf_mode_t mode;
  logic swCfg;
  logic busOn;

  // result group
  logic [17:0] result_ff;
  logic [17:0] nxt_result;

  // configuration group
  logic [3:0] cfgReg_ff;
  logic [3:0] nxt_cfgReg;
  logic [3:0] cfgEff_ff;
  logic [3:0] nxt_cfgEff;

  // bus drive group
  logic [17:0] dout_ff;
  logic [17:0] nxt_dout;
  logic [17:0] doe_ff;
  logic [17:0] nxt_doe;
  logic serEn_ff;
  logic nxt_serEn;

  // reference and buffer groups
  logic refEn_ff;
  logic nxt_refEn;
  logic bufEn_ff;
  logic nxt_bufEn;

  // serial code tested by config and bus groups
  function automatic logic isSerialMode(input arf_mode_t m);
    return m == ARF_SERIAL;
  endfunction

  assign mode = arf_mode_t'({bus_format_sel_msb, bus_format_sel_lsb});
  assign bus.result = result_ff;
  assign bus.mode = mode;
  // coding select follows the pin directly; it is not registered or reset
  assign bus.codingSel = coding_format_sel;
  assign bus.segLo = segment_addr_lo;
  assign bus.segHi = segment_addr_hi;

  arf_lane_map u_map (
    .bus(bus)
  );

  always_comb
  begin
    swCfg = isSerialMode(mode) && !config_source_sel;
    // drivers gated by select and read
    // either strobe high keeps every line released
    busOn = !chipSelect_n && !readData_n;
  end

  // result group: new word only on a valid strobe
  always_comb
  begin
    nxt_result = result_ff;
    if (resultValid)
      nxt_result = resultIn;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      result_ff <= `ARF_RESULT_RST;
    else if (clkEn)
      result_ff <= nxt_result;
  end

  // configuration group
  always_comb
  begin
    nxt_cfgReg = cfgReg_ff;
    if (swCfg && serialCfgLoad)
      nxt_cfgReg = serialCfg;
    // software config replaces pins
    // reads the register, so a load shows one edge later
    nxt_cfgEff = cfgPins;
    if (swCfg)
      nxt_cfgEff = cfgReg_ff;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfgReg_ff <= `ARF_CFG_RST;
      cfgEff_ff <= `ARF_CFG_RST;
    end
    else if (clkEn)
    begin
      cfgReg_ff <= nxt_cfgReg;
      cfgEff_ff <= nxt_cfgEff;
    end
  end

  // bus drive group: data always tracks, enables only on a read
  always_comb
  begin
    nxt_dout = bus.dataOut;
    nxt_doe = `ARF_OE_RST;
    nxt_serEn = 1'h0;
    // serial enable shares the read strobes
    if (busOn)
    begin
      nxt_doe = bus.dataOe;
      nxt_serEn = isSerialMode(mode);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dout_ff <= `ARF_DOUT_RST;
      doe_ff <= `ARF_OE_RST;
      serEn_ff <= `ARF_EN_RST;
    end
    else if (clkEn)
    begin
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      serEn_ff <= nxt_serEn;
    end
  end

  // reference group
  always_comb
  begin
    nxt_refEn = !ref_power_down;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      refEn_ff <= `ARF_EN_RST;
    else if (clkEn)
      refEn_ff <= nxt_refEn;
  end

  // buffer group: the host must keep it on while the reference runs
  always_comb
  begin
    nxt_bufEn = !ref_buffer_power_down;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      bufEn_ff <= `ARF_EN_RST;
    else if (clkEn)
      bufEn_ff <= nxt_bufEn;
  end

  // registered outputs; convAbort follows reset directly
  assign dataOut = dout_ff;
  assign dataOe = doe_ff;
  assign serialOutEn = serEn_ff;
  assign cfgEffective = cfgEff_ff;
  assign refEnable = refEn_ff;
  assign bufEnable = bufEn_ff;
  assign convAbort = reset;
endmodule

/* File: tb/arf_host_model.sv */
// host reading the result bus
`timescale 1ns/100ps
module arf_host_model (
  // bus
  input wire logic rdReq,
  input wire logic selOnly,
  input wire logic [17:0] dataOut,
  input wire logic [17:0] dataOe,
  output logic chipSelect_n,
  output logic readData_n,
  output logic [17:0] busSeen
);
  // select and read; select alone must not open the drivers
  assign chipSelect_n = !(rdReq || selOnly);
  assign readData_n = !rdReq;
  // released lines float, shown inverted
  assign busSeen = dataOe & dataOut | ~dataOe & ~dataOut;
endmodule

/* File: tb/arf_formatter_checker.sv */
// port assertions of the bus formatter
`timescale 1ns/100ps
module arf_formatter_checker (
  // clock, reset, pins
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chipSelect_n,
  input wire logic readData_n,
  input wire logic bus_format_sel_lsb,
  input wire logic bus_format_sel_msb,
  input wire logic config_source_sel,
  input wire logic [3:0] serialCfg,
  input wire logic serialCfgLoad,
  input wire logic ref_power_down,
  input wire logic ref_buffer_power_down,
  // outputs
  input wire logic [17:0] dataOe,
  input wire logic [3:0] cfgEffective,
  input wire logic refEnable,
  input wire logic bufEnable
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire logic rd = !chipSelect_n && !readData_n && !reset;
  wire logic [1:0] md = {bus_format_sel_msb, bus_format_sel_lsb};
  gate_oe_a: assert property (|dataOe |-> $past(rd))
    else $error("oe gate");
  full_oe_a: assert property ($past(rd && md == 2'h0) |-> dataOe == 18'h3ffff)
    else $error("full oe");
  word_oe_a: assert property ($past(rd && md == 2'h1) |-> dataOe == 18'h3fffc)
    else $error("word oe");
  byte_oe_a: assert property ($past(rd && md == 2'h2) |-> dataOe == 18'h3fc00)
    else $error("byte oe");
  serial_off_a: assert property ($past(md == 2'h3) |-> dataOe == 18'h0)
    else $error("serial oe");
  ref_buf_a: assert property (!$past(reset) |-> {refEnable, bufEnable} ==
    ~$past({ref_power_down, ref_buffer_power_down})) else $error("ref");
  rst_clr_a: assert property ($past(reset) |-> !dataOe && !cfgEffective)
    else $error("reset");
  sw_cfg_a: assert property ($past(!reset && md == 2'h3 && !config_source_sel
    && serialCfgLoad, 2) && $past(!reset && md == 2'h3 && !config_source_sel)
    |-> cfgEffective == $past(serialCfg, 2)) else $error("cfg");
endmodule
bind arf_formatter arf_formatter_checker chk (.*);

/* File: tb/arf_formatter_tb_top.sv */
// bench of the bus formatter
`timescale 1ns/100ps
module arf_formatter_tb_top;
  logic core_clk = 0, reset = 1, rq = 0, rv = 0, cod = 1, lo = 0, hi = 0, en = 1, sel = 0;
  logic msb = 0, lsb = 0, css = 1, ld = 0, pdr = 0, pdb = 0, csn, rdn, so, re, be, ab;
  logic [17:0] res = 18'h0, dOut, dOe, seen;
  logic [3:0] sc = 4'h0, ce;
  int failures = 0, samples_checked = 0, cyc = 0;
  initial forever #2 core_clk = ~core_clk;
  arf_formatter dut (.core_clk(core_clk), .reset(reset), .clkEn(en), .resultIn(res),
    .resultValid(rv), .bus_format_sel_lsb(lsb), .bus_format_sel_msb(msb),
    .coding_format_sel(cod), .segment_addr_lo(lo), .segment_addr_hi(hi),
    .config_source_sel(css), .cfgPins(4'h5), .serialCfg(sc), .serialCfgLoad(ld),
    .chipSelect_n(csn), .readData_n(rdn), .ref_power_down(pdr),
    .ref_buffer_power_down(pdb), .dataOut(dOut), .dataOe(dOe), .serialOutEn(so),
    .cfgEffective(ce), .refEnable(re), .bufEnable(be), .convAbort(ab));
  arf_host_model host (.rdReq(rq), .selOnly(sel), .dataOut(dOut), .dataOe(dOe),
    .chipSelect_n(csn), .readData_n(rdn), .busSeen(seen));
  task chk(string n, logic [17:0] e, logic [17:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task rd(logic [3:0] s, logic [17:0] e, logic [17:0] eo);
    @(negedge core_clk);
    {msb, lsb, lo, hi, rq} = {s, 1'h1};
    @(negedge core_clk);
    chk("oe", eo, dOe);
    chk("data", e, seen & eo);
    rq = 0;
  endtask
  task t_modes;
    @(negedge core_clk);
    {res, rv} = {18'h2b5a7, 1'h1};
    @(negedge core_clk);
    rv = 0;
    rd(4'h0, res, 18'h3ffff);
    chk("pins", 18'h5, {14'h0, ce});
    rd(4'h4, res & 18'h3fffc, 18'h3fffc);
    rd(4'h6, {14'h0, res[1:0], 2'h0}, 18'h3fffc);
    rd(4'h8, {res[17:10], 10'h0}, 18'h3fc00);
    rd(4'h9, {res[9:2], 10'h0}, 18'h3fc00);
    rd(4'ha, {6'h0, res[1:0], 10'h0}, 18'h3fc00);
    rd(4'hb, {res[1:0], 16'h0}, 18'h3fc00);
    cod = 0;
    rd(4'h0, res ^ 18'h20000, 18'h3ffff);
    cod = 1;
    rd(4'hc, 18'h0, 18'h0);
    chk("serial", 18'h1, {17'h0, so});
    @(negedge core_clk);
    {msb, lsb, sel} = 3'h1;
    @(negedge core_clk);
    chk("cs only oe", 18'h0, dOe);
    sel = 0;
    // frozen clock enable must not take the new result
    {res, rv, en} = {18'h15a5a, 2'h2};
    @(negedge core_clk);
    {rv, en} = 2'h1;
    rd(4'h0, 18'h2b5a7, 18'h3ffff);
    $display("modes end");
  endtask
  task t_ctl;
    @(negedge core_clk);
    {msb, lsb, css, sc, ld, pdr} = {7'h6a, 2'h3};
    @(negedge core_clk);
    ld = 0;
    @(negedge core_clk);
    chk("cfg", 18'ha, {14'h0, ce});
    chk("ref", 18'h1, {16'h0, re, be});
    @(negedge core_clk);
    reset = 1;
    @(negedge core_clk);
    chk("clear", 18'h10, {13'h0, ab, ce});
    reset = 0;
    @(negedge core_clk);
    chk("cfg reg clear", 18'h0, {14'h0, ce});
    $display("control end");
  endtask
  task summarize;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      failures++;
      summarize;
    end
  end
  initial
  begin
    repeat (3) @(negedge core_clk);
    reset = 0;
    t_modes;
    t_ctl;
    summarize;
  end
endmodule
